// *** verilog/motor_ctrl_protect_speed_regs.sv ***
// Protection, speed command and fault registers behind the serial port,
// with PWM duty, spin-up gain, Hall decoding and the commutation timer.
// Assumes sclk no faster than clk/12 and the host drives frames MSB first.
`timescale 1ns/1ps
`default_nettype none

module motor_ctrl_protect_speed_regs
	import motor_regs_pkg::*;
#(
	parameter int TW = COMM_TIMER_W
) (
	input  wire logic          clk,               // System clock, 10 MHz
	input  wire logic          reset,             // Async reset, high
	input  wire logic          ce,                // Clock enable
	input  wire logic          spi_sel_n,         // Serial select, low
	input  wire logic          spi_sclk,          // Serial clock
	input  wire logic          spi_sdi,           // Serial data in
	output logic               spi_sdo,           // Serial data out
	output logic               spi_sdo_oe,        // Drive enable for data out
	input  wire logic          enable,            // Device enable pin
	input  wire logic [2:0]    hall,              // Hall W,V,U
	input  wire logic [5:0]    fault_in,          // Fault detectors, bit per flag
	input  wire logic          freq_mode,         // 1: clock frequency mode
	input  wire logic          reg_pwm_mode,      // 1: register PWM mode
	input  wire logic          speed_locked_n,    // Lock indicator, low when locked
	output logic [1:0]         fet_overcurrent_sel,       // Threshold code
	output logic               overvoltage_threshold_sel, // Lockout select
	output logic               aux_regulator_en,  // Regulator on
	output logic [9:0]         speed_loop_gain,   // Loop gain
	output logic               pwm_out,           // Register-mode PWM
	output logic [11:0]        spinup_gain,       // Open-loop gain
	output logic               spinup_active,     // Spin-up phase
	output logic [5:0]         phase_drive,       // AH,AL,BH,BL,CH,CL
	output logic [TW-1:0]      comm_period,       // Measured period
	output logic [9:0]         sine_step,         // Sine step index
	output logic               comm_too_slow,     // Below slowest rate
	output logic               comm_too_fast,     // Above fastest rate
	output logic               loop_in_range      // Loop in best band
);

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic        sel_n_f, sclk_f, sdi_f, enable_f;
	logic [2:0]  hall_f;
	logic [5:0]  fault_f;

	pin_sync #(
		.W   (13),
		.RST (13'h1000)
	) u_sync (
		.clk   (clk),
		.reset (reset),
		.ce    (ce),
		.pin   ({spi_sel_n, spi_sclk, spi_sdi, enable, hall, fault_in}),
		.q     ({sel_n_f, sclk_f, sdi_f, enable_f, hall_f, fault_f})
	);

	////////////////////////////////////////////////////////////////////////////
	// Serial frame engine
	spi_state_t  state_r, state_nxt;
	logic        sclk_d_r, sclk_d_nxt;
	logic [4:0]  bitcnt_r, bitcnt_nxt;
	logic [7:0]  head_r, head_nxt;
	logic [15:0] din_r, din_nxt, dout_r, dout_nxt;
	logic        sdo_nxt, sdo_oe_nxt;
	logic        wr_stb_r, wr_stb_nxt;
	logic [6:0]  wr_addr_r, wr_addr_nxt;
	logic [15:0] wr_data_r, wr_data_nxt;
	logic        sclk_rise, sclk_fall;
	logic [6:0]  rd_addr;
	logic [15:0] rd_word;

	logic [15:0] cfg_r, cfg_nxt;
	logic [11:0] speed_r, speed_nxt;
	logic [5:0]  fault_r, fault_nxt;

	assign sclk_rise = sclk_f & ~sclk_d_r;
	assign sclk_fall = ~sclk_f & sclk_d_r;
	assign rd_addr   = {head_r[5:0], sdi_f};

	always_comb begin
		case (rd_addr)
			ADDR_PROT_CFG:  rd_word = cfg_r & PROT_CFG_WMASK;
			ADDR_SPEED_CMD: rd_word = {4'h0, speed_r};
			ADDR_FAULT:     rd_word = {10'h000, fault_r};
			default:        rd_word = 16'h0000;
		endcase
	end

	always_comb begin
		state_nxt   = state_r;
		sclk_d_nxt  = sclk_f;
		bitcnt_nxt  = bitcnt_r;
		head_nxt    = head_r;
		din_nxt     = din_r;
		dout_nxt    = dout_r;
		sdo_nxt     = spi_sdo;
		sdo_oe_nxt  = spi_sdo_oe;
		wr_stb_nxt  = 1'b0;
		wr_addr_nxt = wr_addr_r;
		wr_data_nxt = wr_data_r;
		if (sel_n_f) begin
			state_nxt  = ST_IDLE;
			bitcnt_nxt = '0;
			sdo_nxt    = 1'b0;
			sdo_oe_nxt = 1'b0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					state_nxt  = ST_HEAD;
					bitcnt_nxt = '0;
					sdo_oe_nxt = 1'b1;
				end
				ST_HEAD: begin
					if (sclk_rise) begin
						head_nxt   = {head_r[6:0], sdi_f};
						bitcnt_nxt = bitcnt_r + 5'h01;
						if (bitcnt_r == 5'(HEAD_BITS - 1)) begin
							state_nxt  = ST_DATA;
							bitcnt_nxt = '0;
							dout_nxt   = rd_word;
						end
					end
				end
				ST_DATA: begin
					if (sclk_fall) begin
						sdo_nxt  = dout_r[15];
						dout_nxt = {dout_r[14:0], 1'b0};
					end
					if (sclk_rise) begin
						din_nxt    = {din_r[14:0], sdi_f};
						bitcnt_nxt = bitcnt_r + 5'h01;
						if (bitcnt_r == 5'(WORD_W - 1)) begin
							state_nxt   = ST_DONE;
							wr_stb_nxt  = ~head_r[READ_BIT];
							wr_addr_nxt = head_r[6:0];
							wr_data_nxt = {din_r[14:0], sdi_f};
						end
					end
				end
				ST_DONE: begin
					state_nxt = ST_DONE;
				end
				default: begin
					state_nxt = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_r    <= ST_IDLE;
			sclk_d_r   <= 1'b0;
			bitcnt_r   <= '0;
			head_r     <= '0;
			din_r      <= '0;
			dout_r     <= '0;
			spi_sdo    <= 1'b0;
			spi_sdo_oe <= 1'b0;
			wr_stb_r   <= 1'b0;
			wr_addr_r  <= '0;
			wr_data_r  <= '0;
		end else if (ce) begin
			state_r    <= state_nxt;
			sclk_d_r   <= sclk_d_nxt;
			bitcnt_r   <= bitcnt_nxt;
			head_r     <= head_nxt;
			din_r      <= din_nxt;
			dout_r     <= dout_nxt;
			spi_sdo    <= sdo_nxt;
			spi_sdo_oe <= sdo_oe_nxt;
			wr_stb_r   <= wr_stb_nxt;
			wr_addr_r  <= wr_addr_nxt;
			wr_data_r  <= wr_data_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register file
	always_comb begin
		cfg_nxt   = cfg_r;
		speed_nxt = speed_r;
		fault_nxt = fault_r;
		if (wr_stb_r) begin
			case (wr_addr_r)
				ADDR_PROT_CFG: begin
					cfg_nxt = wr_data_r & PROT_CFG_WMASK;
					if (!enable_f) begin
						cfg_nxt[REG_ON_BIT] = cfg_r[REG_ON_BIT];
					end
				end
				ADDR_SPEED_CMD: begin
					speed_nxt = wr_data_r[SPEED_W-1:0];
				end
				ADDR_FAULT: begin
					fault_nxt = fault_r & wr_data_r[FAULT_W-1:0];
				end
				default: begin
					cfg_nxt = cfg_r;
				end
			endcase
		end
		fault_nxt = fault_nxt | fault_f;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cfg_r   <= PROT_CFG_RESET;
			speed_r <= SPEED_RESET[SPEED_W-1:0];
			fault_r <= FAULT_RESET;
		end else if (ce) begin
			cfg_r   <= cfg_nxt;
			speed_r <= speed_nxt;
			fault_r <= fault_nxt;
		end
	end

	assign fet_overcurrent_sel       = cfg_r[OCP_SEL_HI:OCP_SEL_LO];
	assign overvoltage_threshold_sel = cfg_r[OV_SEL_BIT];
	assign speed_loop_gain           = cfg_r[GAIN_HI:0];

	////////////////////////////////////////////////////////////////////////////
	// Drive outputs
	localparam logic [11:0] PWM_LAST = 12'(PWM_FULL_SCALE - 1);
	localparam logic [TW-1:0] RANGE_LO = TW'(LOOP_PERIOD_MIN);
	localparam logic [TW-1:0] RANGE_HI = TW'(LOOP_PERIOD_MAX);

	logic [11:0] pwm_cnt_r, pwm_cnt_nxt, spinup_gain_nxt;
	logic        pwm_nxt, reg_en_nxt, spinup_nxt, in_range_nxt;
	logic [5:0]  drive_nxt;
	logic        hall_u_d_r;
	logic [TW-1:0] period_w;

	function automatic logic [5:0] hall_decode(input logic [2:0] h);
		case (h)
			3'b101:  hall_decode = 6'b100100;
			3'b100:  hall_decode = 6'b100001;
			3'b110:  hall_decode = 6'b001001;
			3'b010:  hall_decode = 6'b011000;
			3'b011:  hall_decode = 6'b010010;
			3'b001:  hall_decode = 6'b000110;
			default: hall_decode = 6'b000000;
		endcase
	endfunction

	always_comb begin
		pwm_cnt_nxt     = (pwm_cnt_r == PWM_LAST) ? 12'h000 : pwm_cnt_r + 12'h001;
		pwm_nxt         = reg_pwm_mode && (pwm_cnt_nxt < speed_r);
		reg_en_nxt      = cfg_r[REG_ON_BIT] | enable_f;
		spinup_nxt      = freq_mode & speed_locked_n;
		spinup_gain_nxt = spinup_nxt ? speed_r : 12'h000;
		drive_nxt       = hall_decode(hall_f);
		in_range_nxt    = (period_w >= RANGE_LO) && (period_w <= RANGE_HI);
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pwm_cnt_r        <= '0;
			pwm_out          <= 1'b0;
			aux_regulator_en <= 1'b0;
			spinup_active    <= 1'b0;
			spinup_gain      <= '0;
			phase_drive      <= '0;
			loop_in_range    <= 1'b0;
			hall_u_d_r       <= 1'b0;
		end else if (ce) begin
			pwm_cnt_r        <= pwm_cnt_nxt;
			pwm_out          <= pwm_nxt;
			aux_regulator_en <= reg_en_nxt;
			spinup_active    <= spinup_nxt;
			spinup_gain      <= spinup_gain_nxt;
			phase_drive      <= drive_nxt;
			loop_in_range    <= in_range_nxt;
			hall_u_d_r       <= hall_f[0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Commutation timer
	commutation_timer #(
		.TW    (TW),
		.STEPS (SINE_STEPS)
	) u_timer (
		.clk        (clk),
		.reset      (reset),
		.ce         (ce),
		.hall_edge  (hall_f[0] & ~hall_u_d_r),
		.period_r   (period_w),
		.step_idx_r (sine_step),
		.too_slow_r (comm_too_slow),
		.too_fast_r (comm_too_fast)
	);

	assign comm_period = period_w;

endmodule
`default_nettype wire

// *** shared/motor_regs_pkg.sv ***
// Constants for the protection, speed command and fault registers.
// Assumes a 10 MHz system clock and a 24-bit serial frame from the host.
package motor_regs_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Register addresses and word layout
	localparam logic [6:0]  ADDR_PROT_CFG     = 7'h0a;
	localparam logic [6:0]  ADDR_SPEED_CMD    = 7'h0b;
	localparam logic [6:0]  ADDR_FAULT        = 7'h2a;
	localparam int          WORD_W            = 16;
	localparam int          ADDR_W            = 7;
	localparam int          OCP_SEL_HI        = 13;
	localparam int          OCP_SEL_LO        = 12;
	localparam int          OV_SEL_BIT        = 11;
	localparam int          REG_ON_BIT        = 10;
	localparam int          GAIN_HI           = 9;
	localparam int          SPEED_W           = 12;
	localparam int          FAULT_W           = 6;
	localparam logic [15:0] PROT_CFG_WMASK    = 16'h3fff;
	localparam logic [15:0] SPEED_WMASK       = 16'h0fff;
	localparam logic [15:0] FAULT_WMASK       = 16'h003f;
	localparam logic [15:0] PROT_CFG_RESET    = 16'h0000;
	localparam logic [15:0] SPEED_RESET       = 16'h0000;
	localparam logic [5:0]  FAULT_RESET       = 6'h18;

	////////////////////////////////////////////////////////////////////////////
	// Serial frame
	localparam int          HEAD_BITS         = 8;
	localparam int          READ_BIT          = 7;

	////////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int          CLK_HZ            = 10_000_000;
	localparam int          PWM_FULL_SCALE    = 4095;
	localparam int          SINE_STEPS        = 960;
	localparam int          COMM_TIMER_W      = 25;
	localparam int          LOOP_FMIN_HZ      = 50;
	localparam int          LOOP_FMAX_HZ      = 6700;
	localparam int          LOOP_PERIOD_MAX   = CLK_HZ / LOOP_FMIN_HZ;
	localparam int          LOOP_PERIOD_MIN   = CLK_HZ / LOOP_FMAX_HZ;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_HEAD = 2'b01,
		ST_DATA = 2'b11,
		ST_DONE = 2'b10
	} spi_state_t;

endpackage

// *** verilog/pin_sync.sv ***
// Three-stage synchroniser for pin inputs with an agreement filter.
// Assumes pins are asynchronous to clk; output changes when stages 2 and 3 agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int          W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         clk,    // System clock
	input  wire logic         reset,  // Async reset, high
	input  wire logic         ce,     // Clock enable
	input  wire logic [W-1:0] pin,    // Raw pins
	output logic      [W-1:0] q       // Filtered level
);

	logic [W-1:0] s1_r, s2_r, s3_r, q_nxt;

	always_comb begin
		q_nxt = q;
		for (int i = 0; i < W; i++) begin
			if (s2_r[i] == s3_r[i]) begin
				q_nxt[i] = s3_r[i];
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s1_r <= RST;
			s2_r <= RST;
			s3_r <= RST;
			q    <= RST;
		end else if (ce) begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
			q    <= q_nxt;
		end
	end

endmodule
`default_nettype wire

// *** verilog/commutation_timer.sv ***
// Sine commutation timer: measures the electrical period and spreads steps over it.
// Assumes hall_edge is a one-cycle pulse once per electrical cycle.
`timescale 1ns/1ps
`default_nettype none
module commutation_timer
	import motor_regs_pkg::*;
#(
	parameter int TW    = COMM_TIMER_W,
	parameter int STEPS = SINE_STEPS
) (
	input  wire logic          clk,        // System clock
	input  wire logic          reset,      // Async reset, high
	input  wire logic          ce,         // Clock enable
	input  wire logic          hall_edge,  // Start of electrical cycle
	output logic      [TW-1:0] period_r,   // Last measured period
	output logic      [9:0]    step_idx_r, // Sine step 0..STEPS-1
	output logic               too_slow_r, // Period counter saturated
	output logic               too_fast_r  // Period shorter than STEPS
);

	localparam logic [TW-1:0] CNT_MAX  = '1;
	localparam logic [TW:0]   STEP_INC = (TW+1)'(STEPS);
	localparam logic [9:0]    IDX_LAST = 10'(STEPS - 1);

	logic [TW-1:0] cnt_r, cnt_nxt, period_nxt, acc_r, acc_nxt;
	logic [9:0]    step_idx_nxt;
	logic          too_slow_nxt, too_fast_nxt, step;
	logic [TW:0]   sum;

	always_comb begin
		cnt_nxt      = cnt_r;
		period_nxt   = period_r;
		too_slow_nxt = too_slow_r;
		too_fast_nxt = too_fast_r;
		acc_nxt      = acc_r;
		step_idx_nxt = step_idx_r;
		step         = 1'b0;
		sum          = {1'b0, acc_r} + STEP_INC;
		if (hall_edge) begin
			period_nxt   = cnt_r;
			too_fast_nxt = (cnt_r < TW'(STEPS));
			too_slow_nxt = 1'b0;
			cnt_nxt      = TW'(1);
			acc_nxt      = '0;
			step_idx_nxt = '0;
		end else begin
			if (cnt_r == CNT_MAX) begin
				too_slow_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r + TW'(1);
			end
			if (too_fast_r) begin
				step    = 1'b1;
				acc_nxt = '0;
			end else if (sum >= {1'b0, period_r}) begin
				step    = 1'b1;
				acc_nxt = TW'(sum - {1'b0, period_r});
			end else begin
				acc_nxt = sum[TW-1:0];
			end
			if (step && !too_slow_r) begin
				step_idx_nxt = (step_idx_r == IDX_LAST) ? 10'h000 : step_idx_r + 10'h001;
			end
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_r      <= '0;
			period_r   <= '1;
			acc_r      <= '0;
			step_idx_r <= '0;
			too_slow_r <= 1'b0;
			too_fast_r <= 1'b0;
		end else if (ce) begin
			cnt_r      <= cnt_nxt;
			period_r   <= period_nxt;
			acc_r      <= acc_nxt;
			step_idx_r <= step_idx_nxt;
			too_slow_r <= too_slow_nxt;
			too_fast_r <= too_fast_nxt;
		end
	end

endmodule
`default_nettype wire

// *** testbench/motor_regs_chk.sv ***
// Checker on the top module ports of the register block.
// Assumes it is bound into the design top; one clock domain.
`timescale 1ns/1ps
`default_nettype none
module motor_regs_chk
	import motor_regs_pkg::*;
#(
	parameter int TW = COMM_TIMER_W
) (
	input wire logic          clk,              // Clock
	input wire logic          reset,            // Reset
	input wire logic          ce,               // Enable
	input wire logic          enable,           // Enable pin
	input wire logic          freq_mode,        // Mode
	input wire logic          reg_pwm_mode,     // Mode
	input wire logic          speed_locked_n,   // Lock
	input wire logic          aux_regulator_en, // Regulator
	input wire logic [9:0]    speed_loop_gain,  // Gain
	input wire logic          pwm_out,          // PWM
	input wire logic [11:0]   spinup_gain,      // Spin-up gain
	input wire logic          spinup_active,    // Spin-up
	input wire logic [5:0]    phase_drive,      // Gates
	input wire logic [TW-1:0] comm_period,      // Period
	input wire logic          comm_too_fast,    // Fast flag
	input wire logic          loop_in_range,    // Band flag
	input wire logic          spi_sel_n         // Select
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_spin_follow;
		$past(ce) && !$past(reset) |-> spinup_active == $past(freq_mode && speed_locked_n);
	endproperty
	a_spin_follow: assert property (p_spin_follow) else $error("spin-up flag wrong");

	property p_spin_zero;
		!spinup_active |-> spinup_gain == 12'h000;
	endproperty
	a_spin_zero: assert property (p_spin_zero) else $error("spin-up gain outside spin-up");

	property p_phase_pair;
		(phase_drive & (phase_drive >> 1) & 6'h15) == 6'h00;
	endproperty
	a_phase_pair: assert property (p_phase_pair) else $error("both gates of a phase on");

	property p_range_flag;
		$stable(comm_period) |-> loop_in_range == (comm_period >= LOOP_PERIOD_MIN && comm_period <= LOOP_PERIOD_MAX);
	endproperty
	a_range_flag: assert property (p_range_flag) else $error("band flag wrong");

	property p_fast_flag;
		$stable(comm_period) |-> comm_too_fast == (comm_period < SINE_STEPS);
	endproperty
	a_fast_flag: assert property (p_fast_flag) else $error("fast flag wrong");

	property p_aux_on;
		(ce && enable) [*8] |=> aux_regulator_en;
	endproperty
	a_aux_on: assert property (p_aux_on) else $error("regulator off while enabled");

	property p_pwm_off;
		!reg_pwm_mode [*2] |-> !pwm_out;
	endproperty
	a_pwm_off: assert property (p_pwm_off) else $error("pwm active outside mode");

	property p_gain_hold;
		spi_sel_n [*8] |-> $stable(speed_loop_gain);
	endproperty
	a_gain_hold: assert property (p_gain_hold) else $error("gain moved without a frame");
endmodule
`default_nettype wire

// *** testbench/spi_host.sv ***
// Host model: serial master sending 24-bit frames MSB first.
// Assumes the device samples sdi on sclk rise and shifts sdo after fall.
`timescale 1ns/1ps
`default_nettype none
module spi_host (
	input  wire logic clk,    // Clock
	output logic      sel_n,  // Select, low
	output logic      sclk,   // Serial clock
	output logic      sdi,    // Data out
	input  wire logic sdo,    // Data in
	input  wire logic sdo_oe  // Device drives
);
	localparam int HALF = 8;
	initial begin
		sel_n = 1'b1;
		sclk = 1'b0;
		sdi = 1'b0;
	end
	task automatic xfer(input logic rd, input logic [6:0] a, input logic [15:0] wd, output logic [15:0] q);
		logic [23:0] f;
		f = {rd, a, wd};
		q = 16'h0000;
		@(posedge clk) sel_n <= 1'b0;
		repeat (HALF) @(posedge clk);
		for (int i = 23; i >= 0; i--) begin
			sdi <= f[i];
			repeat (HALF) @(posedge clk);
			sclk <= 1'b1;
			if (i < 16)
				q[i] = sdo_oe ? sdo : 1'bx;
			repeat (HALF) @(posedge clk);
			sclk <= 1'b0;
		end
		repeat (HALF) @(posedge clk);
		sel_n <= 1'b1;
		sdi <= ~f[0];
		repeat (2 * HALF) @(posedge clk);
	endtask
endmodule
`default_nettype wire

// *** testbench/motor_ctrl_protect_speed_regs_tb.sv ***
// Testbench: register frames, outputs, faults and Hall rotation.
// Assumes the host model drives the serial pins; ce held high.
`timescale 1ns/1ps
`default_nettype none
module motor_ctrl_protect_speed_regs_tb;
	import motor_regs_pkg::*;
	localparam int TW = COMM_TIMER_W;
	logic          clk, reset, ce, spi_sel_n, spi_sclk, spi_sdi, spi_sdo, spi_sdo_oe;
	logic          enable, freq_mode, reg_pwm_mode, speed_locked_n, pwm_out, spinup_active;
	logic          overvoltage_threshold_sel, aux_regulator_en, comm_too_slow, comm_too_fast, loop_in_range;
	logic [2:0]    hall;
	logic [5:0]    fault_in, phase_drive;
	logic [1:0]    fet_overcurrent_sel;
	logic [9:0]    speed_loop_gain, sine_step;
	logic [11:0]   spinup_gain;
	logic [TW-1:0] comm_period;
	logic [15:0]   hi;
	int            miscompares = 0;
	int            n_checks = 0;

	motor_ctrl_protect_speed_regs #(.TW(TW)) i_motor_ctrl_protect_speed_regs (.clk, .reset, .ce, .spi_sel_n,
		.spi_sclk, .spi_sdi, .spi_sdo, .spi_sdo_oe, .enable, .hall, .fault_in, .freq_mode, .reg_pwm_mode,
		.speed_locked_n, .fet_overcurrent_sel, .overvoltage_threshold_sel, .aux_regulator_en, .speed_loop_gain,
		.pwm_out, .spinup_gain, .spinup_active, .phase_drive, .comm_period, .sine_step, .comm_too_slow,
		.comm_too_fast, .loop_in_range);
	spi_host i_spi_host (.clk, .sel_n(spi_sel_n), .sclk(spi_sclk), .sdi(spi_sdi), .sdo(spi_sdo), .sdo_oe(spi_sdo_oe));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [6:0] a, input logic [15:0] d);
		logic [15:0] q;
		i_spi_host.xfer(1'b0, a, d, q);
	endtask
	task automatic rdc(input logic [6:0] a, input logic [15:0] exp);
		logic [15:0] q;
		i_spi_host.xfer(1'b1, a, 16'h0000, q);
		chk(q, exp);
	endtask
	task automatic end_of_test();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic spin(input int n);
		logic [2:0] s [6];
		logic [5:0] e [6];
		s = '{3'b101, 3'b100, 3'b110, 3'b010, 3'b011, 3'b001};
		e = '{6'b100100, 6'b100001, 6'b001001, 6'b011000, 6'b010010, 6'b000110};
		for (int r = 0; r < 18; r++) begin
			hall <= s[r % 6];
			repeat (n) @(posedge clk);
			chk(phase_drive, e[r % 6]);
		end
		chk(comm_period, 6 * n);
		chk(comm_too_fast, 6 * n < 960);
		chk(loop_in_range, 6 * n >= LOOP_PERIOD_MIN && 6 * n <= LOOP_PERIOD_MAX);
		chk(comm_too_slow, 1'b0);
		// Last U rise seen 5 clk late, so 2n-6 step updates since it
		chk(sine_step, (6 * n < SINE_STEPS) ? 2 * n - 6 : (SINE_STEPS * (2 * n - 6)) / (6 * n));
	endtask

	initial begin
		repeat (60000) @(posedge clk);
		miscompares++;
		end_of_test();
	end

	initial begin
		reset = 1'b1;
		ce = 1'b1;
		enable = 1'b0;
		hall = 3'b101;
		fault_in = 6'h00;
		freq_mode = 1'b0;
		reg_pwm_mode = 1'b0;
		speed_locked_n = 1'b0;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
		repeat (4) @(posedge clk);
		rdc(ADDR_PROT_CFG, 16'h0000);
		rdc(ADDR_SPEED_CMD, 16'h0000);
		rdc(ADDR_FAULT, 16'h0018);
		rdc(7'h00, 16'h0000);
		$display("test reset values done");
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_PROT_CFG, {2'b11, 2'(c), c[0], 1'b1, 10'h155 << c});
			chk(fet_overcurrent_sel, c);
			chk(overvoltage_threshold_sel, c[0]);
			chk(speed_loop_gain, 10'(10'h155 << c));
			rdc(ADDR_PROT_CFG, {2'b00, 2'(c), c[0], 1'b0, 10'h155 << c});
			chk(aux_regulator_en, 1'b0);
		end
		$display("test thresholds done");
		enable <= 1'b1;
		repeat (8) @(posedge clk);
		wr(ADDR_PROT_CFG, 16'h0400);
		enable <= 1'b0;
		repeat (8) @(posedge clk);
		chk(aux_regulator_en, 1'b1);
		wr(ADDR_PROT_CFG, 16'h0000);
		rdc(ADDR_PROT_CFG, 16'h0400);
		enable <= 1'b1;
		repeat (8) @(posedge clk);
		wr(ADDR_PROT_CFG, 16'h0000);
		enable <= 1'b0;
		repeat (8) @(posedge clk);
		chk(aux_regulator_en, 1'b0);
		$display("test regulator done");
		wr(ADDR_SPEED_CMD, 16'hf064);
		rdc(ADDR_SPEED_CMD, 16'h0064);
		reg_pwm_mode <= 1'b1;
		repeat (4100) @(posedge clk);
		hi = 16'h0000;
		repeat (4095) begin
			@(negedge clk);
			hi = hi + pwm_out;
		end
		chk(hi, 100);
		@(posedge clk);
		reg_pwm_mode <= 1'b0;
		freq_mode <= 1'b1;
		speed_locked_n <= 1'b1;
		repeat (4) @(posedge clk);
		chk({spinup_active, spinup_gain}, 13'h1064);
		wr(ADDR_SPEED_CMD, 16'h07ff);
		chk(spinup_gain, 12'h7ff);
		speed_locked_n <= 1'b0;
		repeat (4) @(posedge clk);
		chk({spinup_active, spinup_gain}, 13'h0000);
		freq_mode <= 1'b0;
		$display("test speed command done");
		wr(ADDR_FAULT, 16'h0000);
		rdc(ADDR_FAULT, 16'h0000);
		for (int b = 0; b < 6; b++) begin
			fault_in <= 6'h01 << b;
			repeat (10) @(posedge clk);
			fault_in <= 6'h00;
			rdc(ADDR_FAULT, 16'h0001 << b);
			wr(ADDR_FAULT, 16'hffc0);
		end
		rdc(ADDR_FAULT, 16'h0000);
		$display("test faults done");
		spin(100);
		spin(300);
		hall <= 3'b111;
		repeat (8) @(posedge clk);
		chk(phase_drive, 6'h00);
		$display("test hall done");
		end_of_test();
	end
endmodule

bind motor_ctrl_protect_speed_regs motor_regs_chk #(.TW(TW)) i_motor_regs_chk (.clk, .reset, .ce, .enable,
	.freq_mode, .reg_pwm_mode, .speed_locked_n, .aux_regulator_en, .speed_loop_gain, .pwm_out, .spinup_gain,
	.spinup_active, .phase_drive, .comm_period, .comm_too_fast, .loop_in_range, .spi_sel_n);
`default_nettype wire
